// ---- logic/ssr_sensor.sv ----
// sensor end: report buffer fifo and the power-triggered report transmitter
// assumes the logger controls supply; values arrive as bcd digits
//
// Overview of operation
// - characters sent at 1200 bit/s
// - start, eight data lsb first, stop
// - idle and stop high, start low
// - line raised within 100 ms of power
// - line held low while measuring initially
// - unbounded wait between raise and start
// - report sent unprompted when readings finish
// - receiver ignores edges before first start
// - command mode after report, no more reports
// - new report only after power cycle
// - report opens with tab 0x09
// - dielectric then temperature as ascii decimals
// - third field conductivity as ascii integer
// - carriage return ends measurement values
// - one printable sensor type character
// - checksum after type, covers tab to type
// - checksum is sum modulo 64 plus 32
// - report ends with cr then lf
// - logger triggers reports by switching supply
// - nonzero stored address suppresses the report
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
module ssr_fifo #(
   parameter int unsigned WIDTH = ssr_pkg::DATA_W,
   parameter int unsigned DEPTH = ssr_pkg::FIFO_DEPTH
) (
   input  wire logic             mclk_i,
   input  wire logic             rst_n_i,
   input  wire logic             flush_i,
   input  wire logic             wr_valid_i,
   output logic                  wr_ready_o,
   input  wire logic [WIDTH-1:0] wr_data_i,
   output logic                  rd_valid_o,
   input  wire logic             rd_ready_i,
   output logic [WIDTH-1:0]      rd_data_o
);
   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr_r;
   logic [AW:0]      rd_ptr_r;
   logic             full;
   logic             empty;

   assign full       = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                       (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
   assign empty      = (wr_ptr_r == rd_ptr_r);
   assign wr_ready_o = !full;
   assign rd_valid_o = !empty;
   assign rd_data_o  = mem[rd_ptr_r[AW-1:0]];

   always_ff @(posedge mclk_i) begin
      if (wr_valid_i && !full) begin
         mem[wr_ptr_r[AW-1:0]] <= wr_data_i;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else if (flush_i) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         if (wr_valid_i && !full) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (rd_ready_i && !empty) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
      end
   end
endmodule : ssr_fifo

////////////////////////////////////////////////////////////////////////////////
module ssr_sensor #(
   parameter int unsigned BIT_CYCLES      = ssr_pkg::BIT_CYCLES,
   parameter int unsigned ANNOUNCE_CYCLES = ssr_pkg::ANNOUNCE_CYCLES,
   parameter logic [7:0]  TYPE_CHAR       = ssr_pkg::TYPE_DEFAULT
) (
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   ssr_if.sensor            link,
   input  wire logic        init_done_i,
   input  wire logic        meas_done_i,
   input  wire logic        addr_zero_i,
   input  wire logic [15:0] diel_bcd_i,
   input  wire logic [11:0] temp_bcd_i,
   input  wire logic [19:0] cond_bcd_i,
   output logic             busy_o,
   output logic             cmd_mode_o
);
   function automatic logic [7:0] bcd_char(input logic [3:0] d);
      bcd_char = ssr_pkg::CH_ZERO + {4'h0, d};
   endfunction : bcd_char

   ssr_pkg::ssr_state_t            state_r;
   logic                           pwr_s1_r;
   logic                           pwr_s2_r;
   logic [ssr_pkg::ANN_W-1:0]      ann_cnt_r;
   logic [15:0]                    diel_r;
   logic [11:0]                    temp_r;
   logic [19:0]                    cond_r;
   logic [4:0]                     step_r;
   logic                           nz_r;
   logic [5:0]                     sum_r;
   logic [7:0]                     ch;
   logic [3:0]                     dg;
   logic                           is_dg;
   logic                           sup_ok;
   logic                           skip;
   logic                           push;
   logic                           fifo_wr_ready;
   logic                           fifo_rd_valid;
   logic                           fifo_rd_ready;
   logic [7:0]                     fifo_rd_data;
   logic                           tx_busy_r;
   logic [9:0]                     shift_r;
   logic [3:0]                     bit_cnt_r;
   logic [ssr_pkg::BAUD_W-1:0]     baud_cnt_r;
   logic                           line_r;
   logic                           powered;

   ////////////////////////////////////////////////////////////////////////////
   // supply arrives from the far end: two flip-flops first
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pwr_s1_r <= 1'b0;
         pwr_s2_r <= 1'b0;
      end else begin
         pwr_s1_r <= link.pwr;
         pwr_s2_r <= pwr_s1_r;
      end
   end
   assign powered = pwr_s2_r;

   ////////////////////////////////////////////////////////////////////////////
   // power-up sequence
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r   <= ssr_pkg::SSR_OFF;
         ann_cnt_r <= '0;
      end else if (!powered) begin
         // losing supply is the only way back to a report
         state_r   <= ssr_pkg::SSR_OFF;
         ann_cnt_r <= '0;
      end else begin
         unique case (state_r)
            ssr_pkg::SSR_OFF: begin
               state_r <= ssr_pkg::SSR_LOW;
            end
            ssr_pkg::SSR_LOW: begin
               ann_cnt_r <= ann_cnt_r + 1'b1;
               // deadline forces the raise even if measuring runs long
               if (init_done_i ||
                   ann_cnt_r == ssr_pkg::ANN_W'(ANNOUNCE_CYCLES - 1)) begin
                  state_r <= addr_zero_i ? ssr_pkg::SSR_HIGH
                                         : ssr_pkg::SSR_CMD;
               end
            end
            ssr_pkg::SSR_HIGH: begin
               // no timeout: waits for the readings as long as needed
               if (meas_done_i) begin
                  state_r <= ssr_pkg::SSR_SEND;
               end
            end
            ssr_pkg::SSR_SEND: begin
               if (step_r == ssr_pkg::STEP_END && !fifo_rd_valid &&
                   !tx_busy_r) begin
                  state_r <= ssr_pkg::SSR_CMD;
               end
            end
            ssr_pkg::SSR_CMD: begin
               state_r <= ssr_pkg::SSR_CMD;
            end
            default: begin
               state_r <= ssr_pkg::SSR_OFF;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // character of the current frame step
   always_comb begin
      ch     = 8'h00;
      dg     = 4'h0;
      is_dg  = 1'b0;
      sup_ok = 1'b0;
      case (step_r)
         5'h00: ch = ssr_pkg::CH_TAB;
         5'h01: begin dg = diel_r[15:12]; is_dg = 1'b1; sup_ok = 1'b1; end
         5'h02: begin dg = diel_r[11:8];  is_dg = 1'b1; sup_ok = 1'b1; end
         5'h03: begin dg = diel_r[7:4];   is_dg = 1'b1; end
         5'h04: ch = ssr_pkg::CH_DOT;
         5'h05: begin dg = diel_r[3:0];   is_dg = 1'b1; end
         5'h06: ch = ssr_pkg::CH_SP;
         5'h07: begin dg = temp_r[11:8];  is_dg = 1'b1; sup_ok = 1'b1; end
         5'h08: begin dg = temp_r[7:4];   is_dg = 1'b1; end
         5'h09: ch = ssr_pkg::CH_DOT;
         5'h0A: begin dg = temp_r[3:0];   is_dg = 1'b1; end
         5'h0B: ch = ssr_pkg::CH_SP;
         5'h0C: begin dg = cond_r[19:16]; is_dg = 1'b1; sup_ok = 1'b1; end
         5'h0D: begin dg = cond_r[15:12]; is_dg = 1'b1; sup_ok = 1'b1; end
         5'h0E: begin dg = cond_r[11:8];  is_dg = 1'b1; sup_ok = 1'b1; end
         5'h0F: begin dg = cond_r[7:4];   is_dg = 1'b1; sup_ok = 1'b1; end
         5'h10: begin dg = cond_r[3:0];   is_dg = 1'b1; end
         5'h11: ch = ssr_pkg::CH_CR;
         5'h12: ch = TYPE_CHAR;
         5'h13: ch = ssr_pkg::CKS_OFS + {2'b00, sum_r};
         5'h14: ch = ssr_pkg::CH_CR;
         5'h15: ch = ssr_pkg::CH_LF;
         default: ch = 8'h00;
      endcase
      if (is_dg) begin
         ch = bcd_char(dg);
      end
   end

   // leading zeros dropped, last integer digit always kept
   assign skip = sup_ok && (dg == 4'h0) && !nz_r;
   assign push = (state_r == ssr_pkg::SSR_SEND) &&
                 (step_r < ssr_pkg::STEP_END) && !skip;

   ////////////////////////////////////////////////////////////////////////////
   // frame builder, stalls on a full buffer
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         step_r <= '0;
         nz_r   <= 1'b0;
         sum_r  <= '0;
         diel_r <= '0;
         temp_r <= '0;
         cond_r <= '0;
      end else if (state_r == ssr_pkg::SSR_HIGH && meas_done_i) begin
         diel_r <= diel_bcd_i;
         temp_r <= temp_bcd_i;
         cond_r <= cond_bcd_i;
         step_r <= '0;
         nz_r   <= 1'b0;
         sum_r  <= '0;
      end else if (state_r == ssr_pkg::SSR_SEND &&
                   step_r < ssr_pkg::STEP_END) begin
         if (skip) begin
            step_r <= step_r + 5'h01;
         end else if (fifo_wr_ready) begin
            step_r <= step_r + 5'h01;
            if (step_r <= ssr_pkg::STEP_TYPE) begin
               sum_r <= sum_r + ch[5:0];
            end
            if (is_dg) begin
               nz_r <= 1'b1;
            end else if (ch == ssr_pkg::CH_SP) begin
               nz_r <= 1'b0;
            end
         end
      end
   end

   ssr_fifo #(
      .WIDTH (ssr_pkg::DATA_W),
      .DEPTH (ssr_pkg::FIFO_DEPTH)
   ) u_fifo (
      .mclk_i     (mclk_i),
      .rst_n_i    (rst_n_i),
      .flush_i    (!powered),
      .wr_valid_i (push),
      .wr_ready_o (fifo_wr_ready),
      .wr_data_i  (ch),
      .rd_valid_o (fifo_rd_valid),
      .rd_ready_i (fifo_rd_ready),
      .rd_data_o  (fifo_rd_data)
   );

   assign fifo_rd_ready = !tx_busy_r && (state_r == ssr_pkg::SSR_SEND);

   ////////////////////////////////////////////////////////////////////////////
   // character serialiser
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_busy_r  <= 1'b0;
         shift_r    <= '1;
         bit_cnt_r  <= '0;
         baud_cnt_r <= '0;
      end else if (!powered) begin
         tx_busy_r  <= 1'b0;
         shift_r    <= '1;
         bit_cnt_r  <= '0;
         baud_cnt_r <= '0;
      end else if (!tx_busy_r) begin
         if (fifo_rd_ready && fifo_rd_valid) begin
            shift_r    <= {1'b1, fifo_rd_data, 1'b0};
            tx_busy_r  <= 1'b1;
            bit_cnt_r  <= '0;
            baud_cnt_r <= '0;
         end
      end else if (baud_cnt_r == ssr_pkg::BAUD_W'(BIT_CYCLES - 1)) begin
         baud_cnt_r <= '0;
         shift_r    <= {1'b1, shift_r[9:1]};
         bit_cnt_r  <= bit_cnt_r + 4'h1;
         if (bit_cnt_r == 4'(ssr_pkg::FRAME_BITS - 1)) begin
            tx_busy_r <= 1'b0;
         end
      end else begin
         baud_cnt_r <= baud_cnt_r + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // data line level
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         line_r <= 1'b0;
      end else if (state_r == ssr_pkg::SSR_OFF ||
                   state_r == ssr_pkg::SSR_LOW) begin
         line_r <= 1'b0;
      end else if (tx_busy_r) begin
         line_r <= shift_r[0];
      end else begin
         line_r <= 1'b1;
      end
   end

   assign link.data  = line_r;
   assign busy_o     = (state_r == ssr_pkg::SSR_SEND);
   assign cmd_mode_o = (state_r == ssr_pkg::SSR_CMD);
endmodule : ssr_sensor

// ---- shared/ssr_pkg.sv ----
// constants, characters and state codes of the power-triggered serial report
// assumes a single 50 MHz clock shared by both ends
package ssr_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // timing
   localparam int unsigned CLK_HZ          = 50_000_000;
   localparam int unsigned BAUD_BPS        = 1200;
   localparam int unsigned BIT_CYCLES      = CLK_HZ / BAUD_BPS;
   localparam int unsigned ANNOUNCE_MS     = 100;
   localparam int unsigned ANNOUNCE_CYCLES = (CLK_HZ / 1000) * ANNOUNCE_MS;
   localparam int unsigned BAUD_W          = 16;
   localparam int unsigned ANN_W           = 23;
   localparam int unsigned FRAME_BITS      = 10;

   ////////////////////////////////////////////////////////////////////////////
   // characters of the report
   localparam logic [7:0] CH_TAB  = 8'h09;
   localparam logic [7:0] CH_SP   = 8'h20;
   localparam logic [7:0] CH_DOT  = 8'h2E;
   localparam logic [7:0] CH_CR   = 8'h0D;
   localparam logic [7:0] CH_LF   = 8'h0A;
   localparam logic [7:0] CH_ZERO = 8'h30;
   localparam logic [7:0] CKS_OFS = 8'h20;
   // arbitrary neutral sensor-type character
   localparam logic [7:0] TYPE_DEFAULT = 8'h78;

   ////////////////////////////////////////////////////////////////////////////
   // buffering and frame steps
   localparam int unsigned DATA_W     = 8;
   localparam int unsigned FIFO_DEPTH = 32;
   localparam logic [4:0]  STEP_TYPE  = 5'h12;
   localparam logic [4:0]  STEP_END   = 5'h16;

   ////////////////////////////////////////////////////////////////////////////
   // sensor states, gray along power-up path
   typedef enum logic [2:0] {
      SSR_OFF  = 3'h0,
      SSR_LOW  = 3'h1,
      SSR_HIGH = 3'h3,
      SSR_SEND = 3'h2,
      SSR_CMD  = 3'h6
   } ssr_state_t;

endpackage : ssr_pkg

// ---- shared/ssr_if.sv ----
// one-wire report link: sensor supply from logger, data line from sensor
// assumes both ends clocked by the same clock, joined by the testbench
`timescale 1ns/1ns
interface ssr_if;
   logic pwr;
   logic data;
   modport sensor (input pwr, output data);
   modport logger (output pwr, input data);
endinterface : ssr_if

// ---- logic/ssr_logger.sv ----
// logger end: sensor supply switch, receiver and report checker
// assumes the sensor end on the same clock; data line is synchronised anyway
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
module ssr_logger #(
   parameter int unsigned BIT_CYCLES = ssr_pkg::BIT_CYCLES
) (
   input  wire logic  mclk_i,
   input  wire logic  rst_n_i,
   ssr_if.logger      link,
   input  wire logic  pwr_en_i,
   output logic [7:0] rx_data_o,
   output logic       rx_valid_o,
   output logic       frame_err_o,
   output logic       report_done_o,
   output logic       report_ok_o,
   output logic [7:0] type_o
);
   logic                       pwr_r;
   logic                       d_s1_r;
   logic                       d_s2_r;
   logic                       armed_r;
   logic [ssr_pkg::BAUD_W-1:0] idle_cnt_r;
   logic                       rx_busy_r;
   logic [ssr_pkg::BAUD_W-1:0] rx_baud_r;
   logic [3:0]                 rx_bit_r;
   logic [7:0]                 rx_sh_r;
   logic                       in_rep_r;
   logic                       seen_cr_r;
   logic [1:0]                 meta_r;
   logic [5:0]                 sum_r;
   logic                       ok_r;
   logic                       bit_tick;

   ////////////////////////////////////////////////////////////////////////////
   // supply is the only trigger for a report
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pwr_r <= 1'b0;
      end else begin
         pwr_r <= pwr_en_i;
      end
   end
   assign link.pwr = pwr_r;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         d_s1_r <= 1'b0;
         d_s2_r <= 1'b0;
      end else begin
         d_s1_r <= link.data;
         d_s2_r <= d_s1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // arm only after a full bit time of high: the measuring low and the
   // raise are not framing
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         armed_r    <= 1'b0;
         idle_cnt_r <= '0;
      end else if (!pwr_r) begin
         armed_r    <= 1'b0;
         idle_cnt_r <= '0;
      end else if (!armed_r) begin
         if (!d_s2_r) begin
            idle_cnt_r <= '0;
         end else if (idle_cnt_r == ssr_pkg::BAUD_W'(BIT_CYCLES - 1)) begin
            armed_r <= 1'b1;
         end else begin
            idle_cnt_r <= idle_cnt_r + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // receiver, samples mid-bit
   assign bit_tick = (rx_baud_r == ssr_pkg::BAUD_W'(BIT_CYCLES - 1));

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_busy_r   <= 1'b0;
         rx_baud_r   <= '0;
         rx_bit_r    <= '0;
         rx_sh_r     <= '0;
         rx_data_o   <= '0;
         rx_valid_o  <= 1'b0;
         frame_err_o <= 1'b0;
      end else begin
         rx_valid_o  <= 1'b0;
         frame_err_o <= 1'b0;
         if (!pwr_r) begin
            rx_busy_r <= 1'b0;
         end else if (!rx_busy_r) begin
            if (armed_r && !d_s2_r) begin
               rx_busy_r <= 1'b1;
               rx_bit_r  <= '0;
               rx_baud_r <= ssr_pkg::BAUD_W'(BIT_CYCLES / 2);
            end
         end else if (bit_tick) begin
            rx_baud_r <= '0;
            rx_bit_r  <= rx_bit_r + 4'h1;
            if (rx_bit_r == 4'h0) begin
               if (d_s2_r) begin
                  rx_busy_r <= 1'b0;
               end
            end else if (rx_bit_r < 4'(ssr_pkg::FRAME_BITS - 1)) begin
               rx_sh_r <= {d_s2_r, rx_sh_r[7:1]};
            end else begin
               rx_busy_r <= 1'b0;
               if (d_s2_r) begin
                  rx_data_o  <= rx_sh_r;
                  rx_valid_o <= 1'b1;
               end else begin
                  frame_err_o <= 1'b1;
               end
            end
         end else begin
            rx_baud_r <= rx_baud_r + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // report checker
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         in_rep_r      <= 1'b0;
         seen_cr_r     <= 1'b0;
         meta_r        <= '0;
         sum_r         <= '0;
         ok_r          <= 1'b0;
         report_done_o <= 1'b0;
         report_ok_o   <= 1'b0;
         type_o        <= '0;
      end else begin
         report_done_o <= 1'b0;
         if (frame_err_o) begin
            ok_r <= 1'b0;
         end else if (rx_valid_o) begin
            if (rx_data_o == ssr_pkg::CH_TAB && !seen_cr_r) begin
               in_rep_r  <= 1'b1;
               seen_cr_r <= 1'b0;
               meta_r    <= '0;
               sum_r     <= ssr_pkg::CH_TAB[5:0];
               ok_r      <= 1'b1;
            end else if (in_rep_r && !seen_cr_r) begin
               sum_r <= sum_r + rx_data_o[5:0];
               if (rx_data_o == ssr_pkg::CH_CR) begin
                  seen_cr_r <= 1'b1;
               end
            end else if (in_rep_r) begin
               meta_r <= meta_r + 2'h1;
               unique case (meta_r)
                  2'h0: begin
                     type_o <= rx_data_o;
                     sum_r  <= sum_r + rx_data_o[5:0];
                  end
                  2'h1: begin
                     if (rx_data_o != ssr_pkg::CKS_OFS + {2'b00, sum_r}) begin
                        ok_r <= 1'b0;
                     end
                  end
                  2'h2: begin
                     if (rx_data_o != ssr_pkg::CH_CR) begin
                        ok_r <= 1'b0;
                     end
                  end
                  2'h3: begin
                     in_rep_r      <= 1'b0;
                     seen_cr_r     <= 1'b0;
                     report_done_o <= 1'b1;
                     report_ok_o   <= ok_r && (rx_data_o == ssr_pkg::CH_LF);
                  end
               endcase
            end
         end
      end
   end
endmodule : ssr_logger

// ---- tb/ssr_asserts.sv ----
// link checker: supply and data line of the report link
// assumes both sampled on the shared clock; instanced beside the link
`timescale 1ns/1ns
module ssr_asserts #(
   parameter int BIT_CYCLES      = 16,
   parameter int ANNOUNCE_CYCLES = 64
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic pwr,
   input wire logic data
);
   localparam int ANN_MAX = ANNOUNCE_CYCLES + 10;
   logic [15:0] low_cnt_r;
   logic [15:0] hi_cnt_r;
   logic [15:0] on_cnt_r;
   logic        hi_seen_r;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         low_cnt_r <= 16'h0000;
         hi_cnt_r  <= 16'h0000;
         on_cnt_r  <= 16'h0000;
         hi_seen_r <= 1'b0;
      end else begin
         low_cnt_r <= data ? 16'h0000 : low_cnt_r + 16'h0001;
         hi_cnt_r  <= data ? hi_cnt_r + 16'h0001 : 16'h0000;
         on_cnt_r  <= !pwr ? 16'h0000 :
                      on_cnt_r + 16'(on_cnt_r < 16'(ANN_MAX));
         // lows before the first raise are not serial bits
         hi_seen_r <= pwr && (hi_seen_r || data);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);
   sequence s_off;
      !pwr [*6];
   endsequence
   sequence s_on;
      s_off ##1 pwr;
   endsequence

   off_low_a: assert property (
      s_off |-> !data) else $error("line high with supply off");
   off_fall_a: assert property (
      $fell(pwr) |-> ##[1:6] !data) else $error("line kept after supply off");
   meas_low_a: assert property (
      s_on |-> !data [*4]) else $error("line not low at power up");
   raise_cause_a: assert property (
      $rose(data) |-> $past(pwr, 3)) else $error("line raised without supply");
   announce_by_a: assert property (
      on_cnt_r == 16'(ANN_MAX) |-> hi_seen_r) else $error("line raised late");
   bit_time_a: assert property (
      $rose(data) && hi_seen_r |-> low_cnt_r % BIT_CYCLES == 0
      && low_cnt_r <= 9 * BIT_CYCLES) else $error("low run not whole bits");
   start_low_a: assert property (
      $fell(data) && hi_seen_r |-> !data [*8]) else $error("start bit short");
   stop_len_a: assert property (
      $fell(data) && hi_seen_r |-> hi_cnt_r >= 16'(BIT_CYCLES))
      else $error("stop bit short");
endmodule : ssr_asserts

// ---- tb/tb_top.sv ----
// bench: sensor and logger joined by the link; fifo reached through sensor
// assumes shortened bit and announce counts chosen here
`timescale 1ns/1ns
module tb_top;
   localparam int BIT = 16;
   localparam int ANN = 64;
   logic        mclk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        pwr_en, init_d, meas_d, az, busy, cmd, rxv, ferr, rdone, rok;
   logic [15:0] diel;
   logic [11:0] temp;
   logic [19:0] cond;
   logic [7:0]  rxd, typ;
   logic [7:0]  q[$];
   int          n_mismatch = 0;
   int          compares = 0;

   ssr_if lnk ();
   ssr_sensor #(.BIT_CYCLES(BIT), .ANNOUNCE_CYCLES(ANN)) i_ssr_sensor (
      .mclk_i, .rst_n_i, .link(lnk), .init_done_i(init_d),
      .meas_done_i(meas_d), .addr_zero_i(az), .diel_bcd_i(diel),
      .temp_bcd_i(temp), .cond_bcd_i(cond), .busy_o(busy), .cmd_mode_o(cmd));
   ssr_logger #(.BIT_CYCLES(BIT)) i_ssr_logger (
      .mclk_i, .rst_n_i, .link(lnk), .pwr_en_i(pwr_en), .rx_data_o(rxd),
      .rx_valid_o(rxv), .frame_err_o(ferr), .report_done_o(rdone),
      .report_ok_o(rok), .type_o(typ));
   ssr_asserts #(.BIT_CYCLES(BIT), .ANNOUNCE_CYCLES(ANN)) i_ssr_asserts (
      .mclk_i, .rst_n_i, .pwr(lnk.pwr), .data(lnk.data));

   always #10 mclk_i = ~mclk_i;

   ////////////////////////////////////////////////////////////////////////////
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_i);
      #2;
   endtask : cyc

   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      compares++;
      if (s !== e) begin
         n_mismatch++;
         $display("mismatch at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : chk

   task automatic stop_test();
      if (n_mismatch == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : stop_test

   // leading zeros dropped, lowest integer digit always kept
   function automatic void fmt(input logic [19:0] v, input int nd, nf);
      bit on;
      on = 1'b0;
      for (int i = nd - 1; i >= 0; i--) begin
         if (on || v[4*i+:4] != 4'h0 || i == nf) begin
            q.push_back(8'h30 + 8'(v[4*i+:4]));
            on = 1'b1;
         end
         if (nf > 0 && i == nf)
            q.push_back(8'h2E);
      end
   endfunction : fmt

   task automatic report(input logic a, input logic fast);
      int t, got, s;
      q = {};
      if (a) begin
         q = {8'h09};
         fmt(diel, 4, 1);
         q.push_back(8'h20);
         fmt(temp, 3, 1);
         q.push_back(8'h20);
         fmt(cond, 5, 0);
         q.push_back(8'h0D);
         q.push_back(ssr_pkg::TYPE_DEFAULT);
         s = 0;
         foreach (q[i]) s += q[i];
         q.push_back(8'(s % 64 + 32));
         q.push_back(8'h0D);
         q.push_back(8'h0A);
      end
      az = a;
      pwr_en = 1'b1;
      cyc(6);
      meas_d = 1'b1;
      cyc(1);
      meas_d = 1'b0;
      init_d = fast;
      cyc(1);
      init_d = 1'b0;
      cyc(ANN + 10);
      chk(lnk.data, 1'b1);
      chk(busy, 1'b0);
      meas_d = 1'b1;
      cyc(1);
      meas_d = 1'b0;
      cyc(1);
      chk(busy, a);
      for (t = 0; t < 40000 && cmd !== 1'b1; t++) begin
         if (rxv === 1'b1) begin
            chk(rxd, got < q.size() ? q[got] : 16'hFFFF);
            got++;
         end
         if (ferr === 1'b1 || rdone === 1'b1)
            chk({ferr, rok, typ}, {2'b01, ssr_pkg::TYPE_DEFAULT});
         cyc(1);
      end
      if (t == 40000) begin
         n_mismatch++;
         stop_test();
      end
      chk(16'(got), 16'(q.size()));
      for (t = 0; t < 20 * BIT; t++) begin
         if (rxv === 1'b1)
            chk(rxv, 1'b0);
         cyc(1);
      end
      chk({busy, cmd}, 2'b01);
      pwr_en = 1'b0;
      cyc(8);
      chk({cmd, lnk.data}, 2'b00);
   endtask : report

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      int r;
      {pwr_en, init_d, meas_d, az} = 4'h0;
      {diel, temp, cond} = 48'h0;
      r = $urandom(32'h1CF4);
      cyc(2);
      rst_n_i = 1'b1;
      for (int i = 0; i < 5; i++) begin
         cond[4*i+:4] = 4'($urandom % 10);
         if (i < 4) diel[4*i+:4] = 4'($urandom % 10);
         if (i < 3) temp[4*i+:4] = 4'($urandom % 10);
      end
      report(1'b1, 1'b1);
      {diel, temp, cond} = 48'h0005_000_00000;
      report(1'b1, 1'b0);
      report(1'b0, 1'b1);
      // a suppressed report must not block the next power cycle
      for (int i = 0; i < 5; i++) begin
         cond[4*i+:4] = 4'($urandom % 10);
      end
      report(1'b1, 1'b0);
      chk(typ, ssr_pkg::TYPE_DEFAULT);
      chk(16'(rok), 16'h0001);
      chk({ferr, rxv}, 2'b00);
      stop_test();
   end
endmodule : tb_top
